// File: hw/enc_clear_pkg.sv
// Purpose: shared constants and carriers for the position clear block
// Assumes: one 10 MHz clock, APB register access, 32-bit words
// Notes: source codes index the flat source vector built in the block
package enc_clear_pkg;
    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int UNITS = 4;
    localparam int IDX_W = 2;
    localparam int CNT_W = 32;
    localparam int N_EACH = 4;
    localparam int SRC_W = 6;
    localparam int CLK_HZ = 10000000;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_UNIT_INDEX = 8'h00;
    localparam logic [7:0] OFS_CLEAR_ORIGIN = 8'h04;
    localparam logic [7:0] OFS_TRIGGER_KIND = 8'h08;
    localparam logic [7:0] OFS_CLEAR_COMMAND = 8'h0C;
    localparam logic [7:0] OFS_COUNT_LIVE = 8'h10;
    localparam logic [7:0] OFS_COUNT_CAPTURED = 8'h14;
    localparam int CMD_BIT = 0;

    // ---------------------------------------------------------------
    // Clear origin codes
    // ---------------------------------------------------------------
    localparam logic [SRC_W-1:0] SRC_OFF = 6'h00;
    localparam logic [SRC_W-1:0] SRC_ACQ_TRIG = 6'h01;
    localparam logic [SRC_W-1:0] SRC_ACQ_TRIG_LOST = 6'h02;
    localparam logic [SRC_W-1:0] SRC_ACQ_START = 6'h03;
    localparam logic [SRC_W-1:0] SRC_ACQ_END = 6'h04;
    localparam logic [SRC_W-1:0] SRC_FRAME_TRIG = 6'h05;
    localparam logic [SRC_W-1:0] SRC_FRAME_TRIG_LOST = 6'h06;
    localparam logic [SRC_W-1:0] SRC_FRAME_START = 6'h07;
    localparam logic [SRC_W-1:0] SRC_FRAME_END = 6'h08;
    localparam logic [SRC_W-1:0] SRC_BURST_START = 6'h09;
    localparam logic [SRC_W-1:0] SRC_BURST_END = 6'h0A;
    localparam logic [SRC_W-1:0] SRC_EXPO_START = 6'h0B;
    localparam logic [SRC_W-1:0] SRC_EXPO_END = 6'h0C;
    localparam logic [SRC_W-1:0] SRC_LINE0 = 6'h0D;
    localparam logic [SRC_W-1:0] SRC_USER0 = 6'h11;
    localparam logic [SRC_W-1:0] SRC_CNT_START0 = 6'h15;
    localparam logic [SRC_W-1:0] SRC_CNT_END0 = 6'h19;
    localparam logic [SRC_W-1:0] SRC_TMR_START0 = 6'h1D;
    localparam logic [SRC_W-1:0] SRC_TMR_END0 = 6'h21;
    localparam logic [SRC_W-1:0] SRC_COMB0 = 6'h25;
    localparam logic [SRC_W-1:0] SRC_SW0 = 6'h29;
    localparam logic [SRC_W-1:0] SRC_ACTION0 = 6'h2D;
    localparam logic [SRC_W-1:0] SRC_TRANSPORT0 = 6'h31;
    localparam logic [SRC_W-1:0] SRC_COUNT = 6'h35;

    typedef enum logic [2:0] {
        TRIG_RISE, TRIG_FALL, TRIG_BOTH, TRIG_HOLD_HIGH, TRIG_HOLD_LOW
    } trig_kind_t;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [SRC_W-1:0] RST_ORIGIN = SRC_OFF;
    localparam trig_kind_t RST_KIND = TRIG_RISE;
    localparam logic [CNT_W-1:0] RST_COUNT = 32'h0000_0000;
    localparam logic [IDX_W-1:0] RST_INDEX = 2'h0;

    // Last field sits at bit 0
    typedef struct packed {
        logic expo_end;
        logic expo_start;
        logic burst_end;
        logic burst_start;
        logic frame_end;
        logic frame_start;
        logic frame_trig_lost;
        logic frame_trig;
        logic acq_end;
        logic acq_start;
        logic acq_trig_lost;
        logic acq_trig;
    } camera_events_t;

    typedef struct packed {
        logic [N_EACH-1:0] transport_trig;
        logic [N_EACH-1:0] action;
        logic [N_EACH-1:0] sw_pulse;
        logic [N_EACH-1:0] comb_func_out;
        logic [N_EACH-1:0] tmr_end;
        logic [N_EACH-1:0] tmr_start;
        logic [N_EACH-1:0] cnt_end;
        logic [N_EACH-1:0] cnt_start;
        logic [N_EACH-1:0] user_out_bit;
    } unit_signals_t;

    typedef struct packed {
        logic up;
        logic down;
    } count_step_t;
endpackage

// File: hw/encoder_reset_and_capture.sv
// Purpose: position counter clear selection, clear command and capture
// Assumes: count steps and internal events come from the clk domain;
//          I/O lines arrive from pins and are synchronised here
// Notes: APB slave with zero wait states, unmapped offsets answer pslverr
module encoder_reset_and_capture
    import enc_clear_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_EACH-1:0] line_pin,
    input wire camera_events_t cam_events,
    input wire unit_signals_t unit_signals,
    input wire count_step_t [UNITS-1:0] count_step,
    output logic [UNITS-1:0][CNT_W-1:0] position_now,
    output logic [UNITS-1:0] clearing
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic clear_hit(input trig_kind_t kind,
                                       input logic now,
                                       input logic was);
        case (kind)
            TRIG_RISE: clear_hit = now & ~was;
            TRIG_FALL: clear_hit = ~now & was;
            TRIG_BOTH: clear_hit = now ^ was;
            TRIG_HOLD_HIGH: clear_hit = now;
            TRIG_HOLD_LOW: clear_hit = ~now;
            default: clear_hit = 1'b0;
        endcase
    endfunction

    function automatic logic is_level(input trig_kind_t kind);
        is_level = (kind == TRIG_HOLD_HIGH) || (kind == TRIG_HOLD_LOW);
    endfunction

    // ---------------------------------------------------------------
    // Line synchroniser
    // ---------------------------------------------------------------
    logic [N_EACH-1:0] line_meta_q;
    logic [N_EACH-1:0] line_sync_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_meta_q <= '0;
            line_sync_q <= '0;
        end else begin
            line_meta_q <= line_pin;
            line_sync_q <= line_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // Flat source vector, indexed by origin code
    // ---------------------------------------------------------------
    localparam int FLAT_W = 53;
    logic [FLAT_W-1:0] src_flat;

    // Code 0 is a constant low, so an off origin never sees an edge
    assign src_flat = {unit_signals, line_sync_q, cam_events, 1'b0};

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    wire logic access_w = psel & penable;
    wire logic setup_w = psel & ~penable;
    wire logic hit_index = (paddr == OFS_UNIT_INDEX);
    wire logic hit_origin = (paddr == OFS_CLEAR_ORIGIN);
    wire logic hit_kind = (paddr == OFS_TRIGGER_KIND);
    wire logic hit_cmd = (paddr == OFS_CLEAR_COMMAND);
    wire logic hit_live = (paddr == OFS_COUNT_LIVE);
    wire logic hit_capt = (paddr == OFS_COUNT_CAPTURED);
    wire logic addr_hit = hit_index | hit_origin | hit_kind | hit_cmd
                          | hit_live | hit_capt;
    wire logic wr_w = access_w & pwrite & addr_hit;
    // Captured count is read-only; a write there is an error
    wire logic wr_err = access_w & pwrite & hit_capt;

    assign pready = 1'b1;
    assign pslverr = access_w & (~addr_hit | wr_err);

    logic [IDX_W-1:0] index_q;
    logic [31:0] prdata_q;

    // Out-of-range origin codes fall back to off
    wire logic origin_ok = (pwdata[SRC_W-1:0] < SRC_COUNT)
                           && (pwdata[31:SRC_W] == '0);
    wire logic [SRC_W-1:0] origin_wr = origin_ok ? pwdata[SRC_W-1:0]
                                                 : SRC_OFF;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            index_q <= RST_INDEX;
        end else if (wr_w && hit_index) begin
            index_q <= pwdata[IDX_W-1:0];
        end
    end

    // ---------------------------------------------------------------
    // Per-unit clear and counter
    // ---------------------------------------------------------------
    logic [UNITS-1:0][SRC_W-1:0] origin_all;
    logic [UNITS-1:0][2:0] kind_all;
    logic [UNITS-1:0][CNT_W-1:0] live_all;
    logic [UNITS-1:0][CNT_W-1:0] capt_all;

    for (genvar u = 0; u < UNITS; u++) begin : g_unit
        logic [SRC_W-1:0] origin_q;
        trig_kind_t kind_q;
        logic was_q;
        logic in_clear_q;
        logic [CNT_W-1:0] count_q;
        logic [CNT_W-1:0] capt_q;

        wire logic sel_w = (index_q == IDX_W'(u));
        wire logic src_now = src_flat[origin_q];
        // Off origin never clears from hardware
        wire logic hw_clear = (origin_q != SRC_OFF)
                              & clear_hit(kind_q, src_now, was_q);
        // Command ignores origin
        wire logic sw_clear = wr_w & hit_cmd & sel_w
                              & pwdata[CMD_BIT];
        wire logic clear_now = hw_clear | sw_clear;
        // A held level captures only on entry, else it would capture zero
        wire logic capture = sw_clear
                             | (hw_clear & (~is_level(kind_q)
                                            | ~in_clear_q));
        wire logic preset = wr_w & hit_live & sel_w;

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                origin_q <= RST_ORIGIN;
                kind_q <= RST_KIND;
            end else if (wr_w && sel_w && hit_origin) begin
                origin_q <= origin_wr;
            end else if (wr_w && sel_w && hit_kind) begin
                kind_q <= trig_kind_t'(pwdata[2:0]);
            end
        end

        // Previous sample for edges; a change of origin may show one edge
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                was_q <= 1'b0;
                in_clear_q <= 1'b0;
            end else begin
                was_q <= src_now;
                in_clear_q <= hw_clear;
            end
        end

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                count_q <= RST_COUNT;
            end else if (clear_now) begin
                count_q <= RST_COUNT;
            end else if (preset) begin
                count_q <= pwdata;
            end else if (count_step[u].up && !count_step[u].down) begin
                count_q <= count_q + 32'h0000_0001;
            end else if (count_step[u].down && !count_step[u].up) begin
                count_q <= count_q - 32'h0000_0001;
            end
        end

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                capt_q <= RST_COUNT;
            end else if (capture) begin
                capt_q <= count_q;
            end
        end

        assign origin_all[u] = origin_q;
        assign kind_all[u] = kind_q;
        assign live_all[u] = count_q;
        assign capt_all[u] = capt_q;
        assign clearing[u] = hw_clear;
    end

    assign position_now = live_all;

    // ---------------------------------------------------------------
    // Read data, loaded in the setup cycle
    // ---------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_index) begin
            rd_mux = {{(32-IDX_W){1'b0}}, index_q};
        end else if (hit_origin) begin
            rd_mux = {{(32-SRC_W){1'b0}}, origin_all[index_q]};
        end else if (hit_kind) begin
            rd_mux = {29'h0000_0000, kind_all[index_q]};
        end else if (hit_live) begin
            rd_mux = live_all[index_q];
        end else if (hit_capt) begin
            rd_mux = capt_all[index_q];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_w && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    assign prdata = prdata_q;
endmodule // encoder_reset_and_capture

// File: tb/encoder_reset_and_capture_asserts.sv
// Purpose: port-level checks for the position clear block
// Assumes: single clk domain, sys_rst async active high
// Notes: units 0 and 1 watched; cheap and enough for the bench traffic
module enc_clear_checker
    import enc_clear_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire count_step_t [UNITS-1:0] count_step,
    input wire logic [UNITS-1:0][CNT_W-1:0] position_now,
    input wire logic [UNITS-1:0] clearing
);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_clr_zero;
        clearing[0] |=> position_now[0] == '0;
    endproperty
    a_clr_zero: assert property (p_clr_zero)
        else $error("count not zero after clear");
    property p_clr_step;
        clearing[1] && count_step[1] == 2'b10 |=> position_now[1] == '0;
    endproperty
    a_clr_step: assert property (p_clr_step)
        else $error("count step beat a clear");
    property p_up;
        !clearing[0] && !wr_acc && count_step[0] == 2'b10
        |=> position_now[0] - $past(position_now[0]) == 32'h1;
    endproperty
    a_up: assert property (p_up)
        else $error("up step not counted");
    property p_down;
        !clearing[0] && !wr_acc && count_step[0] == 2'b01
        |=> $past(position_now[0]) - position_now[0] == 32'h1;
    endproperty
    a_down: assert property (p_down)
        else $error("down step not counted");
    // Both step bits high means no motion, so it must also hold still
    property p_hold;
        !clearing[0] && !wr_acc && count_step[0].up == count_step[0].down
        |=> $stable(position_now[0]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved without cause");
    property p_ro;
        wr_acc && paddr == OFS_COUNT_CAPTURED |-> pslverr;
    endproperty
    a_ro: assert property (p_ro)
        else $error("captured write not refused");
    property p_cmd_rd;
        psel && penable && !pwrite && paddr == OFS_CLEAR_COMMAND
        |-> prdata == '0;
    endproperty
    a_cmd_rd: assert property (p_cmd_rd)
        else $error("command register read nonzero");
    property p_level;
        clearing[1] [*2] |-> position_now[1] == '0;
    endproperty
    a_level: assert property (p_level)
        else $error("count not held at zero");
endmodule // enc_clear_checker

bind encoder_reset_and_capture enc_clear_checker u_enc_clear_checker (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .count_step(count_step), .position_now(position_now),
    .clearing(clearing)
);

// File: tb/tb.sv
// Purpose: register-level test of the position clear block
// Assumes: APB slave answers with pready, sources low when idle
// Notes: source code c maps to flat bit c-1 of cam, lines, unit signals
module tb
    import enc_clear_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err_seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [N_EACH-1:0] line_pin;
    camera_events_t cam_events;
    unit_signals_t unit_signals;
    count_step_t [UNITS-1:0] count_step;
    logic [UNITS-1:0][CNT_W-1:0] position_now;
    logic [UNITS-1:0] clearing;
    int n_mismatch, n_checks, j, k;
    // Bit 3 is the first phase; 1 means preset 9 survives
    logic [3:0] kind_mask [6] = '{4'hB, 4'hE, 4'hA, 4'h8, 4'h2, 4'hF};

    encoder_reset_and_capture u_encoder_reset_and_capture (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_pin(line_pin), .cam_events(cam_events),
        .unit_signals(unit_signals), .count_step(count_step),
        .position_now(position_now), .clearing(clearing)
    );

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        forever begin
            @(posedge clk);
            n++;
            if (pready === 1'b1 || n > 20) break;
        end
        // A slave that never answers counts once; the run goes on
        if (n > 20) begin
            n_mismatch++;
        end
        rdat = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic set_src(input int c, input logic v);
        @(posedge clk);
        if (c <= 12) cam_events[c-1] <= v;
        else if (c <= 16) line_pin[c-13] <= v;
        else unit_signals[c-17] <= v;
    endtask
    task automatic step(input int u, input logic [1:0] s, input int n);
        @(posedge clk);
        count_step[u] <= s;
        repeat (n) @(posedge clk);
        count_step[u] <= 2'b00;
    endtask

    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        sys_rst = 1'b1;
        {line_pin, cam_events, unit_signals, count_step} = '0;
        n_mismatch = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        for (k = 0; k <= 'h14; k += 4) rd(k[7:0], 32'h0);
        // Idle wait of 4 covers the line synchroniser delay
        for (k = 1; k <= 52; k++) begin
            wr(OFS_CLEAR_ORIGIN, 32'(k));
            wr(OFS_COUNT_LIVE, 32'(k + 5));
            set_src(k, 1'b1);
            idle(4);
            rd(OFS_COUNT_LIVE, 32'h0);
            rd(OFS_COUNT_CAPTURED, 32'(k + 5));
            set_src(k, 1'b0);
        end
        wr(OFS_UNIT_INDEX, 32'h1);
        wr(OFS_CLEAR_ORIGIN, 32'h1);
        for (k = 0; k < 6; k++) begin
            wr(OFS_TRIGGER_KIND, 32'(k));
            for (j = 0; j < 4; j++) begin
                if (j % 2 == 0) wr(OFS_COUNT_LIVE, 32'h9);
                else set_src(1, j == 1);
                idle(2);
                rd(OFS_COUNT_LIVE, kind_mask[k][3-j] ? 32'h9 : 32'h0);
            end
        end
        wr(OFS_TRIGGER_KIND, 32'h3);
        set_src(1, 1'b1);
        step(1, 2'b10, 3);
        rd(OFS_COUNT_LIVE, 32'h0);
        set_src(1, 1'b0);
        wr(OFS_UNIT_INDEX, 32'h0);
        wr(OFS_CLEAR_ORIGIN, 32'h0);
        wr(OFS_COUNT_LIVE, 32'h3);
        set_src(52, 1'b1);
        idle(4);
        rd(OFS_COUNT_LIVE, 32'h3);
        chk(position_now[1], 32'h0);
        set_src(52, 1'b0);
        wr(OFS_CLEAR_COMMAND, 32'h1);
        rd(OFS_COUNT_LIVE, 32'h0);
        rd(OFS_COUNT_CAPTURED, 32'h3);
        rd(OFS_CLEAR_COMMAND, 32'h0);
        step(0, 2'b10, 3);
        step(0, 2'b01, 1);
        rd(OFS_COUNT_LIVE, 32'h2);
        wr(OFS_COUNT_CAPTURED, 32'hFF);
        chk({31'h0, err_seen}, 32'h1);
        rd(OFS_COUNT_CAPTURED, 32'h3);
        rd(8'h18, 32'h0);
        report_and_stop();
    end
endmodule // tb
